// >>> hdl/uph_defines.svh
// Offsets, field positions, reset values and codes of the transceiver block
`ifndef UPH_DEFINES_SVH
`define UPH_DEFINES_SVH

`define UPH_OFS_XCN        8'hD7
`define UPH_OFS_IADR       8'h96
`define UPH_OFS_IDAT       8'h97

`define UPH_XCN_PULLUP_EN  7
`define UPH_XCN_XCVR_EN    6
`define UPH_XCN_SPEED      5
`define UPH_XCN_TST_HI     4
`define UPH_XCN_TST_LO     3
`define UPH_XCN_DIFF_RX    2
`define UPH_XCN_PLUS       1
`define UPH_XCN_MINUS      0

`define UPH_IADR_BUSY      7
`define UPH_IADR_AUTO      6
`define UPH_IADR_SEL_HI    5
`define UPH_IADR_SEL_LO    0

`define UPH_RST_BYTE       8'h00
`define UPH_RST_SEL        6'h00
`define UPH_RST_TST        2'h0

`define UPH_TST_NORMAL     2'h0
`define UPH_TST_DIFF1      2'h1
`define UPH_TST_DIFF0      2'h2
`define UPH_TST_SE0        2'h3

`endif

// >>> hdl/uph_pkg.sv
// Types shared by the transceiver control block
package uph_pkg;

    typedef enum logic [2:0]
    {
        uph_st_idle = 3'h1,
        uph_st_rd   = 3'h2,
        uph_st_wr   = 3'h4
    } uph_state_t;

endpackage : uph_pkg

// >>> hdl/uph_ind_if.sv
// Carrier between register decode and the indirect access engine
`timescale 1ns/100ps
interface uph_ind_if;
    logic       start_rd;
    logic       start_wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       busy;
    logic [7:0] data;

    modport ctl (output start_rd, output start_wr, output addr,
                 output wdata, input busy, input data);
    modport eng (input start_rd, input start_wr, input addr,
                 input wdata, output busy, output data);
endinterface : uph_ind_if

// >>> hdl/uph_ind_eng.sv
// Indirect access engine towards the core register port
`timescale 1ns/100ps
`include "uph_defines.svh"
module uph_ind_eng
(
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    uph_ind_if.eng          ind,
    output logic [5:0]      core_addr_out,
    output logic            core_rd_out,
    output logic            core_wr_out,
    output logic [7:0]      core_wdata_out,
    input  wire logic [7:0] core_rdata_in,
    input  wire logic       core_ack_in
);
    uph_pkg::uph_state_t state;
    logic [7:0]          data;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state <= uph_pkg::uph_st_idle;
        else
            case (state)
                uph_pkg::uph_st_idle:
                    if (ind.start_rd)
                        state <= uph_pkg::uph_st_rd;
                    else if (ind.start_wr)
                        state <= uph_pkg::uph_st_wr;
                uph_pkg::uph_st_rd,
                uph_pkg::uph_st_wr:
                    if (core_ack_in)
                        state <= uph_pkg::uph_st_idle;
                default:
                    state <= uph_pkg::uph_st_idle;
            endcase
    end

    // Address is frozen for the whole access
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            core_addr_out <= `UPH_RST_SEL;
        else if (state == uph_pkg::uph_st_idle
                 && (ind.start_rd || ind.start_wr))
            core_addr_out <= ind.addr;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            data <= `UPH_RST_BYTE;
        else if (state == uph_pkg::uph_st_idle && ind.start_wr
                 && !ind.start_rd)
            data <= ind.wdata;
        else if (state == uph_pkg::uph_st_rd && core_ack_in)
            data <= core_rdata_in;
    end

    assign core_rd_out    = (state == uph_pkg::uph_st_rd);
    assign core_wr_out    = (state == uph_pkg::uph_st_wr);
    assign core_wdata_out = data;
    assign ind.busy       = (state != uph_pkg::uph_st_idle);
    assign ind.data       = data;

    a_read_forward: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        !ind.busy && ind.start_rd |=> core_rd_out
            && core_addr_out == $past(ind.addr))
        else $error("read not forwarded to selected register");
    a_busy_holds: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        (core_rd_out || core_wr_out) && !core_ack_in |=> ind.busy)
        else $error("busy dropped before core answered");
    a_read_capture: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        core_rd_out && core_ack_in |=> !ind.busy
            && ind.data == $past(core_rdata_in))
        else $error("read data not valid when busy clears");
    a_write_forward: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        !ind.busy && ind.start_wr && !ind.start_rd |=> core_wr_out
            && core_wdata_out == $past(ind.wdata))
        else $error("write byte not forwarded");

    c_read_done: cover property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) core_rd_out && core_ack_in);
    c_write_done: cover property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) core_wr_out && core_ack_in);
endmodule : uph_ind_eng

// >>> hdl/uph_top.sv
// Transceiver control and indirect core register port
//
// Notes on behaviour
// - Speed 0 puts the pull-up on D- for low speed, 1 on D+ for full.
// - With the transceiver enabled, bit 2 reads 1 for differential one.
// - Bit 1 reads the sampled level of D+.
// - Bit 0 reads the sampled level of D-.
// - Core registers are reached only through the address and data pair.
// - The endpoint index is written first, then indexed accesses hit it.
// - Address register: busy bit 7, auto-read bit 6, address 5:0, reset 0.
// - Busy reads 1 while an access runs, 0 once the data is valid.
// - Auto-read off needs a busy write per read; on, a data read restarts.
// - Read: wait idle, load address, write busy 1, wait idle, read data.
// - Write: wait idle, load address, write data; it goes to the core.
// - The pull-up connects only while bus supply is detected and enabled.
`timescale 1ns/100ps
`include "uph_defines.svh"
module uph_top
(
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic [7:0]      sfr_rdata_out,
    input  wire logic       vbus_in,
    input  wire logic       dp_in,
    output logic            dp_out,
    output logic            dp_oe_n_out,
    input  wire logic       dm_in,
    output logic            dm_out,
    output logic            dm_oe_n_out,
    output logic            dp_pullup_out,
    output logic            dm_pullup_out,
    output logic [5:0]      core_addr_out,
    output logic            core_rd_out,
    output logic            core_wr_out,
    output logic [7:0]      core_wdata_out,
    input  wire logic [7:0] core_rdata_in,
    input  wire logic       core_ack_in
);
    logic       pullup_enable;
    logic       transceiver_enable;
    logic       speed_full;
    logic [1:0] line_force_test;
    logic       diff_receiver_state;
    logic       plus_line_level;
    logic       minus_line_level;
    logic       auto_read_flag;
    logic [5:0] core_reg_select;
    logic       wr_xcn;
    logic       wr_iadr;
    logic       wr_idat;
    logic       rd_idat;
    logic       rd_iadr;
    logic [7:0] next_rdata;

    uph_ind_if ind ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    assign wr_xcn  = sfr_wr_in && hit(sfr_addr_in, `UPH_OFS_XCN);
    assign wr_iadr = sfr_wr_in && hit(sfr_addr_in, `UPH_OFS_IADR);
    assign wr_idat = sfr_wr_in && hit(sfr_addr_in, `UPH_OFS_IDAT);
    assign rd_iadr = sfr_rd_in && hit(sfr_addr_in, `UPH_OFS_IADR);
    assign rd_idat = sfr_rd_in && hit(sfr_addr_in, `UPH_OFS_IDAT);

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pullup_enable      <= 1'b0;
            transceiver_enable <= 1'b0;
            speed_full         <= 1'b0;
            line_force_test    <= `UPH_RST_TST;
        end
        else if (wr_xcn)
        begin
            pullup_enable      <= sfr_wdata_in[`UPH_XCN_PULLUP_EN];
            transceiver_enable <= sfr_wdata_in[`UPH_XCN_XCVR_EN];
            speed_full         <= sfr_wdata_in[`UPH_XCN_SPEED];
            line_force_test    <=
                sfr_wdata_in[`UPH_XCN_TST_HI:`UPH_XCN_TST_LO];
        end
    end

    // Pin inputs are synchronous, so one sampling stage is enough
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            plus_line_level     <= 1'b0;
            minus_line_level    <= 1'b0;
            diff_receiver_state <= 1'b0;
        end
        else
        begin
            plus_line_level     <= dp_in;
            minus_line_level    <= dm_in;
            diff_receiver_state <= transceiver_enable && dp_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dp_pullup_out <= 1'b0;
            dm_pullup_out <= 1'b0;
        end
        else
        begin
            dp_pullup_out <= pullup_enable && vbus_in
                             && speed_full;
            dm_pullup_out <= pullup_enable && vbus_in
                             && !speed_full;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dp_out      <= 1'b0;
            dm_out      <= 1'b0;
            dp_oe_n_out <= 1'b1;
            dm_oe_n_out <= 1'b1;
        end
        else
        begin
            dp_out      <= (line_force_test == `UPH_TST_DIFF1);
            dm_out      <= (line_force_test == `UPH_TST_DIFF0);
            dp_oe_n_out <= (line_force_test == `UPH_TST_NORMAL);
            dm_oe_n_out <= (line_force_test == `UPH_TST_NORMAL);
        end
    end

    // Address writes during an access are dropped so the core sees a stable
    // target; software is expected to poll busy first anyway
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            auto_read_flag  <= 1'b0;
            core_reg_select <= `UPH_RST_SEL;
        end
        else if (wr_iadr && !ind.busy)
        begin
            auto_read_flag  <= sfr_wdata_in[`UPH_IADR_AUTO];
            core_reg_select <=
                sfr_wdata_in[`UPH_IADR_SEL_HI:`UPH_IADR_SEL_LO];
        end
    end

    assign ind.start_rd = !ind.busy
        && ((wr_iadr && sfr_wdata_in[`UPH_IADR_BUSY])
            || (rd_idat && auto_read_flag));
    assign ind.start_wr = !ind.busy && wr_idat;
    // Same-write address and busy: the new address must be used at once
    assign ind.addr  = wr_iadr
        ? sfr_wdata_in[`UPH_IADR_SEL_HI:`UPH_IADR_SEL_LO] : core_reg_select;
    assign ind.wdata = sfr_wdata_in;

    always_comb
    begin
        next_rdata = `UPH_RST_BYTE;
        if (hit(sfr_addr_in, `UPH_OFS_XCN))
            next_rdata = {pullup_enable, transceiver_enable, speed_full,
                          line_force_test, diff_receiver_state,
                          plus_line_level, minus_line_level};
        else if (hit(sfr_addr_in, `UPH_OFS_IADR))
            next_rdata = {ind.busy, auto_read_flag, core_reg_select};
        else if (hit(sfr_addr_in, `UPH_OFS_IDAT))
            next_rdata = ind.data;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            sfr_rdata_out <= `UPH_RST_BYTE;
        else if (sfr_rd_in)
            sfr_rdata_out <= next_rdata;
    end

    uph_ind_eng uph_ind_eng_i
    (
        .clk_sys_in     (clk_sys_in),
        .arst_n_in      (arst_n_in),
        .ind            (ind.eng),
        .core_addr_out  (core_addr_out),
        .core_rd_out    (core_rd_out),
        .core_wr_out    (core_wr_out),
        .core_wdata_out (core_wdata_out),
        .core_rdata_in  (core_rdata_in),
        .core_ack_in    (core_ack_in)
    );

    a_pullup_plus: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        pullup_enable && vbus_in && speed_full
            |=> dp_pullup_out && !dm_pullup_out)
        else $error("full speed pull-up not on D+");
    a_pullup_minus: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        pullup_enable && vbus_in && !speed_full
            |=> dm_pullup_out && !dp_pullup_out)
        else $error("low speed pull-up not on D-");
    a_pullup_vbus: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        !vbus_in |=> !dp_pullup_out && !dm_pullup_out)
        else $error("pull-up connected without bus supply");
    a_force_diff0: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        line_force_test == `UPH_TST_DIFF0 |=> !dp_oe_n_out
            && !dm_oe_n_out && !dp_out && dm_out)
        else $error("forced differential zero wrong");
    a_force_normal: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        line_force_test == `UPH_TST_NORMAL |=> dp_oe_n_out && dm_oe_n_out)
        else $error("lines driven in normal mode");
    a_diff_receiver: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        transceiver_enable && dp_in && !dm_in ##1 sfr_rd_in
            && hit(sfr_addr_in, `UPH_OFS_XCN) |=> sfr_rdata_out[2])
        else $error("differential one not reported");
    a_line_levels: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        ##1 sfr_rd_in && hit(sfr_addr_in, `UPH_OFS_XCN) |=>
            sfr_rdata_out[1:0] == {$past(dp_in, 2), $past(dm_in, 2)})
        else $error("line level bits wrong");
    a_addr_layout: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        rd_iadr |=> sfr_rdata_out == {$past(ind.busy),
            $past(auto_read_flag), $past(core_reg_select)})
        else $error("address register layout wrong");
    a_auto_read: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        rd_idat && auto_read_flag && !ind.busy |=> ind.busy
            && core_addr_out == $past(core_reg_select))
        else $error("auto-read did not restart");
    a_manual_read: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        rd_idat && !auto_read_flag && !ind.busy |=> !ind.busy)
        else $error("read started without busy write");

    c_auto_read: cover property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) rd_idat && auto_read_flag && !ind.busy);
    c_force_se0: cover property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) line_force_test == `UPH_TST_SE0);
    c_full_attach: cover property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) dp_pullup_out);
endmodule : uph_top

// >>> bench/uph_core_model.sv
// Behavioural model of the core register file behind the indirect port
`timescale 1ns/100ps
module uph_core_model
(
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic [3:0] lat_in,
    input  wire logic [5:0] addr_in,
    input  wire logic       rd_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    output logic [7:0]      rdata_out,
    output logic            ack_out
);
    logic [7:0] mem [0:63];
    logic [7:0] ep  [0:255];
    logic [3:0] cnt;
    logic [7:0] fifo_cnt;
    logic [7:0] slot;
    logic       idx;
    assign slot = {mem[14][3:0], addr_in[3:0]};
    assign idx  = (addr_in[5:4] == 2'h1);

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ack_out <= 1'b0;
            cnt <= 4'h0;
            fifo_cnt <= 8'h10;
            rdata_out <= 8'h00;
            for (int i = 0; i < 64; i++) mem[i] <= 8'h00;
            for (int i = 0; i < 256; i++) ep[i] <= 8'h00;
        end
        else
        begin
            ack_out <= 1'b0;
            // Idle bus toggles so a stale sample never looks right
            rdata_out <= ~rdata_out;
            if (ack_out) cnt <= 4'h0;
            else if (rd_in || wr_in)
            begin
                if (cnt != lat_in) cnt <= cnt + 4'h1;
                else
                begin
                    ack_out <= 1'b1;
                    if (wr_in && idx) ep[slot] <= wdata_in;
                    else if (wr_in) mem[addr_in] <= wdata_in;
                    if (rd_in && addr_in[5:2] == 4'h8)
                    begin
                        rdata_out <= fifo_cnt;
                        fifo_cnt <= fifo_cnt + 8'h01;
                    end
                    else if (rd_in && idx) rdata_out <= ep[slot];
                    else if (rd_in) rdata_out <= mem[addr_in];
                end
            end
        end
    end
endmodule : uph_core_model

// >>> bench/uph_top_test.sv
// Self-checking bench of the transceiver control and indirect port
`timescale 1ns/100ps
`include "uph_defines.svh"
module uph_top_test;
    logic       clk_sys_in, arst_n_in, s_wr, s_rd, vbus, dp_drv, dm_drv;
    logic       dp_o, dp_oe_n, dm_o, dm_oe_n, dp_pu, dm_pu, c_rd, c_wr;
    logic       c_ack, dp_w, dm_w;
    logic [7:0] s_addr, s_wdata, s_rdata, c_wdata, c_rdata, rd_val;
    logic [5:0] c_addr;
    logic [3:0] lat;
    logic [3:0] tst_exp [4];
    int         error_cnt, tests_run;

    // Wire level: pin driver wins over the far side when enabled
    assign dp_w = dp_oe_n ? dp_drv : dp_o;
    assign dm_w = dm_oe_n ? dm_drv : dm_o;

    uph_top uph_top_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .sfr_addr_in(s_addr), .sfr_wr_in(s_wr), .sfr_rd_in(s_rd),
        .sfr_wdata_in(s_wdata), .sfr_rdata_out(s_rdata), .vbus_in(vbus),
        .dp_in(dp_w), .dp_out(dp_o), .dp_oe_n_out(dp_oe_n), .dm_in(dm_w),
        .dm_out(dm_o), .dm_oe_n_out(dm_oe_n), .dp_pullup_out(dp_pu),
        .dm_pullup_out(dm_pu), .core_addr_out(c_addr), .core_rd_out(c_rd),
        .core_wr_out(c_wr), .core_wdata_out(c_wdata),
        .core_rdata_in(c_rdata), .core_ack_in(c_ack));

    uph_core_model uph_core_model_i (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .lat_in(lat), .addr_in(c_addr),
        .rd_in(c_rd), .wr_in(c_wr), .wdata_in(c_wdata),
        .rdata_out(c_rdata), .ack_out(c_ack));

    task automatic check(input string name, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys_in);
        s_addr = a;
        s_wdata = d;
        s_wr = 1'b1;
        @(negedge clk_sys_in);
        s_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys_in);
        s_addr = a;
        s_rd = 1'b1;
        @(negedge clk_sys_in);
        s_rd = 1'b0;
        @(negedge clk_sys_in);
        rd_val = s_rdata;
    endtask : rd

    task automatic wait_idle;
        for (int i = 0; i < 40; i++)
        begin
            rd(`UPH_OFS_IADR);
            if (rd_val[7] === 1'b0) break;
        end
        check("busy clear", rd_val & 8'h80, 8'h00);
    endtask : wait_idle

    task automatic core_read(input logic [5:0] a);
        wait_idle();
        wr(`UPH_OFS_IADR, {2'b10, a});
        wait_idle();
        rd(`UPH_OFS_IDAT);
    endtask : core_read

    task automatic core_write(input logic [5:0] a, input logic [7:0] d);
        wait_idle();
        wr(`UPH_OFS_IADR, {2'b00, a});
        wr(`UPH_OFS_IDAT, d);
    endtask : core_write

    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // Clock runs throughout, so the core side is always clocked
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        #1000000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        {arst_n_in, s_wr, s_rd, vbus, dp_drv, dm_drv} = 6'h00;
        {s_addr, s_wdata, lat} = 20'h00000;
        error_cnt = 0;
        tests_run = 0;
        tst_exp = '{4'hC, 4'h2, 4'h1, 4'h0};
        repeat (4) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        rd(`UPH_OFS_IADR);
        check("address reset", rd_val, 8'h00);
        rd(`UPH_OFS_IDAT);
        check("data reset", rd_val, 8'h00);
        rd(8'h55);
        check("unmapped", rd_val, 8'h00);
        rd(`UPH_OFS_XCN);
        check("control reset", rd_val, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            vbus = s[1];
            wr(`UPH_OFS_XCN, {2'b10, s[0], 5'h00});
            @(negedge clk_sys_in);
            check("pull-ups", {6'h00, dp_pu, dm_pu},
                  {6'h00, s[1] & s[0], s[1] & ~s[0]});
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(`UPH_OFS_XCN, {3'h0, m[1:0], 3'h0});
            @(negedge clk_sys_in);
            check("line force", {4'h0, dp_oe_n, dm_oe_n, dp_o, dm_o},
                  {4'h0, tst_exp[m]});
        end
        for (int k = 0; k < 8; k++)
        begin
            {dp_drv, dm_drv} = k[1:0];
            wr(`UPH_OFS_XCN, {1'b0, k[2], 6'h00});
            rd(`UPH_OFS_XCN);
            check("line status", rd_val, {1'b0, k[2], 3'h0,
                  k[2] & k[1], k[1], k[0]});
        end
        for (int l = 0; l < 2; l++)
        begin
            lat = l[0] ? 4'h9 : 4'h0;
            core_write(6'h05 + 6'(l), 8'hA5 ^ 8'(l));
            core_read(6'h05 + 6'(l));
            check("core data", rd_val, 8'hA5 ^ 8'(l));
        end
        wr(`UPH_OFS_IADR, 8'h85);
        rd(`UPH_OFS_IADR);
        check("busy set", rd_val, 8'h85);
        wr(`UPH_OFS_IDAT, 8'hFF);
        core_read(6'h05);
        check("write while busy", rd_val, 8'hA5);
        lat = 4'h2;
        core_write(6'h0E, 8'h02);
        core_write(6'h11, 8'h3C);
        core_write(6'h0E, 8'h01);
        core_read(6'h11);
        check("other endpoint", rd_val, 8'h00);
        core_write(6'h0E, 8'h02);
        core_read(6'h11);
        check("indexed", rd_val, 8'h3C);
        lat = 4'h9;
        wr(`UPH_OFS_IADR, 8'hE0);
        wait_idle();
        rd(`UPH_OFS_IDAT);
        check("auto first", rd_val, 8'h10);
        rd(`UPH_OFS_IADR);
        check("auto restart", rd_val, 8'hE0);
        wait_idle();
        rd(`UPH_OFS_IDAT);
        check("auto second", rd_val, 8'h11);
        wait_idle();
        wr(`UPH_OFS_IADR, 8'h20);
        rd(`UPH_OFS_IDAT);
        check("auto third", rd_val, 8'h12);
        rd(`UPH_OFS_IADR);
        check("manual no start", rd_val, 8'h20);
        rd(`UPH_OFS_IDAT);
        check("manual repeat", rd_val, 8'h12);
        print_verdict();
    end
endmodule : uph_top_test
